/* File: logic/pcr_pkg.sv */
package pcr_pkg;
  // ==========================================================================
  // power modes
  localparam logic [1:0] PCR_MODE_RUN = 2'h0;
  localparam logic [1:0] PCR_MODE_STBY = 2'h1;
  localparam logic [1:0] PCR_MODE_SLEEP = 2'h2;
  localparam logic [1:0] PCR_MODE_DEEP = 2'h3;
  // ==========================================================================
  // clock sources
  localparam logic [1:0] PCR_SRC_XTAL = 2'h0;
  localparam logic [1:0] PCR_SRC_LPXTAL = 2'h1;
  localparam logic [1:0] PCR_SRC_FRC = 2'h2;
  localparam logic [1:0] PCR_SRC_LPRC = 2'h3;
  localparam logic [2:0] PCR_DIV_RST = 3'h1;
  // ==========================================================================
  // reset causes, one-hot
  localparam int PCR_NCAUSE = 5;
  localparam int PCR_C_POR = 0;
  localparam int PCR_C_WAKE = 1;
  localparam int PCR_C_DEEP = 2;
  localparam int PCR_C_WDOG = 3;
  localparam int PCR_C_SW = 4;
  // ==========================================================================
  // interrupts
  localparam int PCR_NIRQ = 22;
  localparam logic [15:0] PCR_VEC_BASE = 16'h0003;
  localparam logic [15:0] PCR_VEC_STEP = 16'h0008;
  localparam logic [15:0] PCR_RESET_PC = 16'h0000;
  // ==========================================================================
  // timing
  localparam int PCR_CLK_MHZ = 250;
  localparam int PCR_SWITCH_NS = 16;
  localparam int PCR_SWITCH_CYC = (PCR_SWITCH_NS * PCR_CLK_MHZ + 999) / 1000;
  localparam logic [15:0] PCR_MON_RST = 16'h0100;
  localparam int PCR_TRIM_W = 8;
  localparam logic [7:0] PCR_TRIM_RST = 8'h80;
  localparam int PCR_NSCR = 4;
  localparam int PCR_RSTSYNC = 2;
endpackage

/* File: logic/pcr_scratch_mem.sv */
`timescale 1ns/1ps
// ==========================================================================
// retained scratch bytes: no reset, contents survive every core reset
module pcr_scratch_mem
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [PCR_NSCR];

  // write port; no reset on purpose so the bytes outlive any reset
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end
endmodule

/* File: logic/pcr_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// (RULE1) two-bit field picks run, standby, sleep, deep
// (RULE2) standby halts core, exits on enabled interrupt
// (RULE3) sleep powers down core and peripherals
// (RULE4) two xram blocks retained individually in sleep
// (RULE5) sleep exits on port or controller interrupt
// (RULE6) deep sleep keeps only four scratch bytes
// (RULE7) deep sleep exits only on wake pin low
// (RULE8) system clock from one of four oscillators
// (RULE9) power-of-two prescaler on selected oscillator
// (RULE10) reset selects fast rc divided by two
// (RULE11) clock switch any time, glitch free
// (RULE12) switch waits until new oscillator runs
// (RULE13) readable clock switch status
// (RULE14) clock monitor falls back to fast rc
// (RULE15) frequency locked loop trims internal oscillator
// (RULE16) reference lost keeps last trim value
// (RULE17) fetch begins at address zero after reset
// (RULE18) reset restores defaults except scratch bytes
// (RULE19) core reset on por, wake, watchdog, software
// (RULE20) last reset cause readable by software
// (RULE21) 22 sources, enable and two priorities each
// (RULE22) vectors at 0x0003 stepping eight bytes
// (RULE23) core reset async assert, sync release
module pcr_ctrl
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic power_control_register_we,
  input wire logic [1:0] power_control_register_mode,
  output logic [1:0] power_mode,
  output logic [PCR_NCAUSE-1:0] reset_cause,
  output logic core_halt,
  output logic periph_off,
  output logic radio_off,
  input wire logic [1:0] xram_keep,
  output logic [1:0] xram_off,
  input wire logic wake_pin,
  input wire logic [PCR_NIRQ-1:0] irq_pending,
  input wire logic [PCR_NIRQ-1:0] irq_enable,
  input wire logic [PCR_NIRQ-1:0] irq_priority,
  input wire logic [PCR_NIRQ-1:0] irq_wake_src,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [15:0] reset_pc,
  input wire logic watchdog_expire,
  input wire logic sw_reset,
  output logic core_rst_n,
  input wire logic clk_we,
  input wire logic [1:0] clk_src,
  input wire logic [2:0] clk_div,
  input wire logic [3:0] osc_running,
  output logic [1:0] clk_sel,
  output logic [2:0] clk_div_sel,
  output logic clk_switching,
  output logic [1:0] clk_pending_src,
  input wire logic sys_clk_edge,
  input wire logic [15:0] mon_limit,
  output logic clk_mon_trip,
  input wire logic fll_en,
  input wire logic fll_ref_running,
  input wire logic fll_fast,
  input wire logic fll_slow,
  output logic [PCR_TRIM_W-1:0] osc_trim,
  input wire logic scr_we,
  input wire logic [1:0] scr_addr,
  input wire logic [7:0] scr_wdata,
  output logic [7:0] scr_rdata
);
  // ==========================================================================
  // pin synchronisers
  logic wake_s1_q, wake_s2_q;
  logic [3:0] osc_s1_q, osc_s2_q;
  logic ref_s1_q, ref_s2_q;

  // pins come from other domains; only the second stage is read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_s1_q <= 1'b1;
      wake_s2_q <= 1'b1;
      osc_s1_q <= 4'h0;
      osc_s2_q <= 4'h0;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_pin;
      wake_s2_q <= wake_s1_q;
      osc_s1_q <= osc_running;
      osc_s2_q <= osc_s1_q;
      ref_s1_q <= fll_ref_running;
      ref_s2_q <= ref_s1_q;
    end
  end

  // ==========================================================================
  // power mode state machine
  typedef enum logic [3:0] {
    PCR_ST_RUN = 4'h1,
    PCR_ST_STBY = 4'h2,
    PCR_ST_SLEEP = 4'h4,
    PCR_ST_DEEP = 4'h8
  } pcr_state_t;
  pcr_state_t state_q;
  logic wake_irq, any_irq, leave_pulse;

  assign any_irq = |(irq_pending & irq_enable); // RULE2
  assign wake_irq = |(irq_pending & irq_enable & irq_wake_src); // RULE5

  // mode change by software write, exits by wake events
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= PCR_ST_RUN;
    end else begin
      case (state_q)
        PCR_ST_RUN: begin
          if (power_control_register_we) begin // RULE1
            case (power_control_register_mode)
              PCR_MODE_STBY: state_q <= PCR_ST_STBY;
              PCR_MODE_SLEEP: state_q <= PCR_ST_SLEEP;
              PCR_MODE_DEEP: state_q <= PCR_ST_DEEP;
              default: state_q <= PCR_ST_RUN;
            endcase
          end
        end
        PCR_ST_STBY: if (any_irq) state_q <= PCR_ST_RUN; // RULE2
        PCR_ST_SLEEP: if (wake_irq) state_q <= PCR_ST_RUN; // RULE5
        PCR_ST_DEEP: if (!wake_s2_q) state_q <= PCR_ST_RUN; // RULE7
        default: state_q <= PCR_ST_RUN;
      endcase
    end
  end

  // leaving sleep or deep sleep restarts the core
  assign leave_pulse = (state_q == PCR_ST_SLEEP && wake_irq) ||
                       (state_q == PCR_ST_DEEP && !wake_s2_q); // RULE19

  always_comb begin
    case (state_q)
      PCR_ST_STBY: power_mode = PCR_MODE_STBY;
      PCR_ST_SLEEP: power_mode = PCR_MODE_SLEEP;
      PCR_ST_DEEP: power_mode = PCR_MODE_DEEP;
      default: power_mode = PCR_MODE_RUN;
    endcase
  end

  // power gating outputs per mode
  assign core_halt = (state_q != PCR_ST_RUN); // RULE2
  assign periph_off = (state_q == PCR_ST_SLEEP) || (state_q == PCR_ST_DEEP); // RULE3
  assign radio_off = (state_q == PCR_ST_DEEP); // RULE6
  // in sleep xram blocks dropped unless software keeps them; deep loses both
  assign xram_off = (state_q == PCR_ST_SLEEP) ? ~xram_keep : // RULE4
                    (state_q == PCR_ST_DEEP) ? 2'h3 : 2'h0; // RULE6

  // ==========================================================================
  // core reset and reset cause
  logic [PCR_RSTSYNC-1:0] rst_sh_q;
  logic cause_req;
  logic [PCR_NCAUSE-1:0] cause_d;

  // any of these forces a fresh core reset
  assign cause_req = leave_pulse || watchdog_expire || sw_reset; // RULE19

  always_comb begin
    cause_d = '0;
    if (leave_pulse && state_q == PCR_ST_DEEP) cause_d[PCR_C_DEEP] = 1'b1;
    else if (leave_pulse) cause_d[PCR_C_WAKE] = 1'b1;
    else if (watchdog_expire) cause_d[PCR_C_WDOG] = 1'b1;
    else cause_d[PCR_C_SW] = 1'b1;
  end

  // last cause held until the next reset event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_cause <= PCR_NCAUSE'(1) << PCR_C_POR; // RULE20
    end else if (cause_req) begin
      reset_cause <= cause_d; // RULE20
    end
  end

  // async assert from pin, release after two clean clock edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sh_q <= '0; // RULE23
    end else if (cause_req) begin
      rst_sh_q <= '0; // RULE19
    end else begin
      rst_sh_q <= {rst_sh_q[PCR_RSTSYNC-2:0], 1'b1}; // RULE23
    end
  end
  assign core_rst_n = rst_sh_q[PCR_RSTSYNC-1];
  assign reset_pc = PCR_RESET_PC; // RULE17

  // ==========================================================================
  // interrupt priority and vector
  logic [4:0] irq_idx_d;
  logic irq_hit_d;
  logic [PCR_NIRQ-1:0] act;

  assign act = irq_pending & irq_enable; // RULE21

  // high-priority first, lowest index wins within a level
  always_comb begin
    irq_idx_d = 5'h0;
    irq_hit_d = 1'b0;
    for (int i = PCR_NIRQ - 1; i >= 0; i--) begin
      if (act[i] && !irq_priority[i]) begin
        irq_idx_d = 5'(i);
        irq_hit_d = 1'b1;
      end
    end
    for (int i = PCR_NIRQ - 1; i >= 0; i--) begin
      if (act[i] && irq_priority[i]) begin // RULE21
        irq_idx_d = 5'(i);
        irq_hit_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req <= 1'b0;
      irq_vector <= PCR_VEC_BASE;
    end else begin
      irq_req <= irq_hit_d;
      irq_vector <= PCR_VEC_BASE + 16'({irq_idx_d, 3'h0}); // RULE22
    end
  end

  // ==========================================================================
  // clock select, glitch-free switch and monitor
  logic [1:0] pend_q;
  logic [2:0] div_pend_q;
  logic busy_q;
  logic [7:0] sw_cnt_q;
  logic [15:0] mon_cnt_q;

  // new source waits for its oscillator, then a fixed handover gap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_sel <= PCR_SRC_FRC; // RULE10
      clk_div_sel <= PCR_DIV_RST; // RULE10
      pend_q <= PCR_SRC_FRC;
      div_pend_q <= PCR_DIV_RST;
      busy_q <= 1'b0;
      sw_cnt_q <= 8'h0;
      clk_mon_trip <= 1'b0;
    end else if (mon_cnt_q >= mon_limit && mon_limit != 16'h0) begin
      clk_sel <= PCR_SRC_FRC; // RULE14
      clk_div_sel <= PCR_DIV_RST;
      pend_q <= PCR_SRC_FRC;
      div_pend_q <= PCR_DIV_RST;
      busy_q <= 1'b0;
      clk_mon_trip <= 1'b1;
    end else if (clk_we) begin // RULE11
      pend_q <= clk_src; // RULE8
      div_pend_q <= clk_div; // RULE9
      busy_q <= 1'b1;
      sw_cnt_q <= 8'h0;
    end else if (busy_q) begin
      if (osc_s2_q[pend_q]) begin // RULE12
        sw_cnt_q <= sw_cnt_q + 8'h1;
        if (sw_cnt_q == 8'(PCR_SWITCH_CYC - 1)) begin // RULE11
          clk_sel <= pend_q;
          clk_div_sel <= div_pend_q;
          busy_q <= 1'b0;
        end
      end
    end
  end
  assign clk_switching = busy_q; // RULE13
  assign clk_pending_src = pend_q; // RULE13

  // counts cycles without an edge of the system clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_cnt_q <= 16'h0;
    end else if (sys_clk_edge || busy_q || mon_cnt_q >= mon_limit) begin
      mon_cnt_q <= 16'h0;
    end else begin
      mon_cnt_q <= mon_cnt_q + 16'h1; // RULE14
    end
  end

  // ==========================================================================
  // frequency locked loop trim
  // one step per cycle; slow but never overshoots by more than an lsb
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_trim <= PCR_TRIM_RST;
    end else if (fll_en && ref_s2_q) begin // RULE15 RULE16
      if (fll_fast && osc_trim != '0) osc_trim <= osc_trim - 8'h1;
      else if (fll_slow && osc_trim != '1) osc_trim <= osc_trim + 8'h1;
    end
    // reference gone: trim simply holds (RULE16)
  end

  // ==========================================================================
  // retained scratch bytes, untouched by reset
  pcr_scratch_mem u_scratch (
    .clk(clk),
    .we(scr_we),
    .addr(scr_addr),
    .wdata(scr_wdata),
    .rdata(scr_rdata)
  ); // RULE18
endmodule

/* File: dv/pcr_monitor.sv */
`timescale 1ns/1ps
// ==========================================================
// port checks for the controller, one clock domain
module pcr_monitor
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic power_control_register_we,
  input wire logic [1:0] power_control_register_mode,
  input wire logic [1:0] power_mode,
  input wire logic [PCR_NCAUSE-1:0] reset_cause,
  input wire logic core_halt,
  input wire logic periph_off,
  input wire logic radio_off,
  input wire logic [1:0] xram_keep,
  input wire logic [1:0] xram_off,
  input wire logic wake_pin,
  input wire logic [PCR_NIRQ-1:0] irq_pending,
  input wire logic [PCR_NIRQ-1:0] irq_enable,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] clk_sel,
  input wire logic clk_switching,
  input wire logic clk_mon_trip
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // mode and power-down levels
  a_mode_take: assert property (
    power_control_register_we && power_mode == PCR_MODE_RUN |=> power_mode == $past(power_control_register_mode))
    else $error("mode write not taken");
  a_stby_halt: assert property (
    power_mode == PCR_MODE_STBY |-> core_halt && !periph_off)
    else $error("standby levels wrong");
  a_sleep_off: assert property (
    power_mode == PCR_MODE_SLEEP |-> core_halt && periph_off && xram_off == ~xram_keep)
    else $error("sleep levels wrong");
  a_deep_off: assert property (
    power_mode == PCR_MODE_DEEP |-> radio_off && periph_off && xram_off == 2'h3)
    else $error("deep sleep levels wrong");
  // the pin passes a two-stage synchroniser, so look back two cycles
  a_deep_hold: assert property (
    power_mode == PCR_MODE_DEEP && wake_pin && $past(wake_pin) && $past(wake_pin, 2)
    |=> power_mode == PCR_MODE_DEEP) else $error("deep sleep left without pin");
  a_deep_wake: assert property (
    power_mode == PCR_MODE_DEEP && !wake_pin
    |-> ##[1:4] power_mode == PCR_MODE_RUN && reset_cause[PCR_C_DEEP])
    else $error("pin low did not wake");
  // interrupt request and vector slots
  a_irq_req: assert property (
    1'b1 |=> irq_req == |($past(irq_pending) & $past(irq_enable)))
    else $error("irq request wrong");
  a_vec_slot: assert property (
    irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h00AB)
    else $error("vector off slot");
  // clock switch keeps the glitch gap, monitor falls back to fast rc
  a_switch_gap: assert property (
    $fell(clk_switching) && $past(arst_n) |-> $past(clk_switching, 4))
    else $error("switch too short");
  a_mon_fall: assert property (
    $rose(clk_mon_trip) |-> ##[0:1] clk_sel == PCR_SRC_FRC) else $error("no fallback");
  c_switch: cover property ($fell(clk_switching));
  c_deep: cover property (power_mode == PCR_MODE_DEEP ##1 power_mode == PCR_MODE_RUN);
  c_trip: cover property ($rose(clk_mon_trip));
endmodule

bind pcr_ctrl pcr_monitor i_pcr_monitor (.*);

/* File: dv/pcr_partner.sv */
`timescale 1ns/1ps
// ==========================================================
// oscillator bank and system clock activity
module pcr_partner
  import pcr_pkg::*;
#(
  parameter int XTAL_START = 12
)
(
  input wire logic clk,
  input wire logic xtal_en,
  input wire logic stop_edge,
  output logic [3:0] osc_running = 4'hC,
  output logic sys_clk_edge = 1'b1
);
  int cnt = 0;
  // crystals need start-up time, rc sources run at once
  // rising edge, so the bench's falling-edge stimulus never races it
  always @(posedge clk) begin
    cnt <= xtal_en ? cnt + 1 : 0;
    osc_running <= {2'h3, {2{xtal_en && cnt >= XTAL_START}}};
    sys_clk_edge <= !stop_edge;
  end
endmodule

/* File: dv/test_power_clock_reset_control.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the controller
module test_power_clock_reset_control
  import pcr_pkg::*;
;
  logic clk = 0, arst_n = 1, power_control_register_we = 0, wake_pin = 1, watchdog_expire = 0, sw_reset = 0;
  logic clk_we = 0, fll_en = 0, fll_ref_running = 0, fll_fast = 0, fll_slow = 0, scr_we = 0;
  logic xtal_en = 0, stop_edge = 0, core_halt, periph_off, radio_off, irq_req, core_rst_n;
  logic clk_switching, clk_mon_trip, sys_clk_edge;
  logic [1:0] power_control_register_mode = 0, xram_keep = 0, clk_src = 0, scr_addr = 0;
  logic [1:0] power_mode, xram_off, clk_sel, clk_pending_src;
  logic [2:0] clk_div = 0, clk_div_sel;
  logic [3:0] osc_running;
  logic [7:0] scr_wdata = 0, scr_rdata, osc_trim;
  logic [15:0] irq_vector, reset_pc, mon_limit = 0;
  logic [PCR_NCAUSE-1:0] reset_cause;
  logic [PCR_NIRQ-1:0] irq_pending = 0, irq_enable = 0, irq_priority = 0, irq_wake_src = 0;
  int err_total = 0, tests_run = 0;
  typedef struct packed {
    logic [1:0] mode, keep, xoff;
    logic poff;
    logic [4:0] cause;
  } pcr_row_t;
  pcr_row_t rows [4] = '{'{PCR_MODE_STBY, 2'h0, 2'h0, 1'b0, 5'h01},
    '{PCR_MODE_SLEEP, 2'h1, 2'h2, 1'b1, 5'h02}, '{PCR_MODE_SLEEP, 2'h2, 2'h1, 1'b1, 5'h02},
    '{PCR_MODE_DEEP, 2'h0, 2'h3, 1'b1, 5'h04}};

  pcr_ctrl i_pcr_ctrl (.*);
  pcr_partner i_pcr_partner (.*);

  initial forever #2 clk = ~clk;

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait: 0 mode, 1 switch done, 2 trip, 3 core out, 4 core in reset
  task automatic wait_for(input int k, input logic [1:0] m);
    int n;
    n = 0;
    while (!(k == 0 ? power_mode === m : k == 1 ? clk_switching === 1'b0 :
        k == 2 ? clk_mon_trip === 1'b1 : core_rst_n === (k == 3))) begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        err_total++;
        final_report();
      end
    end
  endtask
  task automatic mode(input logic [1:0] m);
    power_control_register_mode = m;
    power_control_register_we = 1;
    @(negedge clk);
    power_control_register_we = 0;
    // let an edge pass so a following write never re-raises the strobe at once
    @(negedge clk);
  endtask
  // a false trigger must not wake, a real one must
  task automatic trig(input logic [1:0] m, input logic real_one);
    irq_pending[5] = 1;
    irq_enable[5] = (m != PCR_MODE_STBY) || real_one;
    irq_wake_src[5] = (m == PCR_MODE_DEEP) || real_one;
    wake_pin = !(m == PCR_MODE_DEEP && real_one);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    #1 arst_n = 0;
    repeat (6) @(negedge clk);
    chk(power_mode, PCR_MODE_RUN);
    chk(clk_sel, PCR_SRC_FRC);
    chk(clk_div_sel, PCR_DIV_RST);
    chk(reset_cause, 5'h01);
    chk(osc_trim, 8'h80);
    arst_n = 1;
    @(negedge clk);
    chk(core_rst_n, 0);
    @(negedge clk);
    chk(core_rst_n, 1);
    chk(reset_pc, 16'h0000);
    foreach (rows[i]) begin
      xram_keep = rows[i].keep;
      mode(rows[i].mode);
      chk(power_mode, rows[i].mode);
      chk(core_halt, 1);
      chk(periph_off, rows[i].poff);
      chk(radio_off, rows[i].mode == PCR_MODE_DEEP);
      chk(xram_off, rows[i].xoff);
      trig(rows[i].mode, 0);
      mode(PCR_MODE_RUN);
      repeat (8) @(negedge clk);
      chk(power_mode, rows[i].mode);
      trig(rows[i].mode, 1);
      wait_for(0, PCR_MODE_RUN);
      chk(reset_cause, rows[i].cause);
      irq_pending = 0;
      irq_enable = 0;
      wake_pin = 1;
      wait_for(3, 0);
    end
    // priority and vector placement
    irq_enable = '1;
    irq_pending = 22'h000408;
    @(negedge clk);
    chk(irq_vector, 16'h001B);
    irq_priority[10] = 1;
    @(negedge clk);
    chk(irq_vector, 16'h0053);
    irq_pending = 22'h200000;
    @(negedge clk);
    chk(irq_vector, 16'h00AB);
    irq_enable = 0;
    @(negedge clk);
    chk(irq_req, 0);
    // scratch survives watchdog and software resets
    scr_addr = 2'h2;
    scr_wdata = 8'h5A;
    scr_we = 1;
    @(negedge clk);
    scr_we = 0;
    for (int k = 0; k < 2; k++) begin
      watchdog_expire = (k == 1);
      sw_reset = (k == 0);
      @(negedge clk);
      watchdog_expire = 0;
      sw_reset = 0;
      wait_for(4, 0);
      wait_for(3, 0);
      chk(reset_cause, k ? 5'h08 : 5'h10);
      chk(scr_rdata, 8'h5A);
    end
    // switch waits for the crystal to start
    clk_src = PCR_SRC_XTAL;
    clk_div = 3'h3;
    clk_we = 1;
    @(negedge clk);
    clk_we = 0;
    chk(clk_switching, 1);
    chk(clk_pending_src, PCR_SRC_XTAL);
    repeat (20) @(negedge clk);
    chk(clk_sel, PCR_SRC_FRC);
    xtal_en = 1;
    wait_for(1, 0);
    chk(clk_sel, PCR_SRC_XTAL);
    chk(clk_div_sel, 3'h3);
    mon_limit = 16'h0010;
    stop_edge = 1;
    wait_for(2, 0);
    chk(clk_sel, PCR_SRC_FRC);
    mon_limit = 0;
    stop_edge = 0;
    // back to back requests, the later one wins
    clk_src = PCR_SRC_LPRC;
    clk_we = 1;
    @(negedge clk);
    clk_src = PCR_SRC_LPXTAL;
    @(negedge clk);
    clk_we = 0;
    wait_for(1, 0);
    chk(clk_sel, PCR_SRC_LPXTAL);
    // trim follows the reference, then freezes
    fll_en = 1;
    fll_ref_running = 1;
    repeat (4) @(negedge clk);
    fll_slow = 1;
    repeat (4) @(negedge clk);
    fll_slow = 0;
    chk(osc_trim, 8'h84);
    fll_ref_running = 0;
    repeat (3) @(negedge clk);
    fll_fast = 1;
    repeat (6) @(negedge clk);
    chk(osc_trim, 8'h84);
    // reset in mid-run, off the clock edge
    #1 arst_n = 0;
    #1 chk(core_rst_n, 0);
    chk(clk_sel, PCR_SRC_FRC);
    chk(clk_div_sel, PCR_DIV_RST);
    chk(osc_trim, 8'h80);
    repeat (6) @(negedge clk);
    arst_n = 1;
    wait_for(3, 0);
    chk(scr_rdata, 8'h5A);
    final_report();
  end
endmodule
